// >>> verilog/rcc_pkg.sv
// constants for the reset, strap capture and clock start block
// assumes a single 40 MHz reference clock and a power-on reset beside the reset pin
// How it works
// - data pins 6:0 latched during reset
// - address pins 19:2 latched during reset
// - system clock full or half speed
// - generator runs only while enable high
// - oscillator ratios 1, 1/2, 1/4, crystal 1/16
// - oscillator output high for external source
package rcc_pkg;
    localparam int RCC_DATA_W = 7;
    localparam int RCC_ADDR_W = 18;
    localparam int RCC_SYNC_W = 2;
    // strap fields inside the captured data byte
    localparam int RCC_HALF_BIT = 0;
    localparam int RCC_MODE_LSB = 1;
    localparam int RCC_MODE_W = 2;
    localparam logic [RCC_DATA_W-1:0] RCC_DATA_RST = 7'h7f;
    localparam logic [RCC_ADDR_W-1:0] RCC_ADDR_RST = 18'h3ffff;
    // least reset length in memory clocks; memory clock is half the core clock
    localparam int RCC_RESET_MEM_CYC = 256;
    localparam int RCC_MEM_DIV = 2;
    localparam int RCC_RESET_CYC = RCC_RESET_MEM_CYC * RCC_MEM_DIV;
    localparam int RCC_RCNT_W = 10;
    localparam int RCC_LOCK_EDGES = 4;
    localparam int RCC_LCNT_W = 4;
    localparam int RCC_DIV_W = 2;

    typedef enum logic [1:0] {
        RCC_OSC_X1 = 2'b00,
        RCC_OSC_X2 = 2'b01,
        RCC_OSC_X4 = 2'b10,
        RCC_XTAL_X16 = 2'b11
    } rcc_osc_mode_t;

    // core clocks per oscillator period for each mode
    function automatic logic [4:0] rcc_mult(input rcc_osc_mode_t mode);
        unique case (mode)
            RCC_OSC_X1: rcc_mult = 5'h01;
            RCC_OSC_X2: rcc_mult = 5'h02;
            RCC_OSC_X4: rcc_mult = 5'h04;
            RCC_XTAL_X16: rcc_mult = 5'h10;
        endcase
    endfunction
endpackage

// >>> verilog/rcc_clk_if.sv
// carrier between the strap/reset control and the clock generator
// assumes both ends sit on ref_clk_in
`timescale 1ns/1ps
interface rcc_clk_if;
    import rcc_pkg::*;
    logic gen_enable;
    rcc_osc_mode_t mode;
    logic half_speed;
    logic osc_sync;
    logic running;
    logic memory_clock;
    logic system_clock;
    logic osc_out;
    logic [4:0] mult;
    modport gen (input gen_enable, mode, half_speed, osc_sync,
                 output running, memory_clock, system_clock, osc_out, mult);
    modport ctl (output gen_enable, mode, half_speed, osc_sync,
                 input running, memory_clock, system_clock, osc_out, mult);
endinterface

// >>> verilog/rcc_clock_gen.sv
// clock generator: oscillator qualification and clock dividers
// assumes osc_sync is already synchronised to ref_clk_in
`timescale 1ns/1ps
module rcc_clock_gen
    import rcc_pkg::*;
#(
    parameter int LOCK_EDGES = RCC_LOCK_EDGES
) (
    input wire logic ref_clk_in,    // core clock
    input wire logic rstn_in,       // async reset, active low
    rcc_clk_if.gen cif              // control side
);
    typedef enum logic [1:0] {
        RCC_GEN_OFF = 2'b00,
        RCC_GEN_LOCK = 2'b01,
        RCC_GEN_RUN = 2'b10
    } rcc_gen_state_t;

    rcc_gen_state_t state_reg, state_next;
    logic [RCC_LCNT_W-1:0] edges_reg, edges_next;
    logic osc_prev_reg, osc_prev_next;
    logic [RCC_DIV_W-1:0] div_reg, div_next;
    logic osc_rise;

    assign osc_rise = cif.osc_sync & ~osc_prev_reg;

    always_comb begin
        state_next = state_reg;
        edges_next = edges_reg;
        osc_prev_next = cif.osc_sync;
        div_next = div_reg;
        unique case (state_reg)
            RCC_GEN_OFF: begin
                edges_next = '0;
                if (cif.gen_enable) begin
                    state_next = RCC_GEN_LOCK;
                end
            end
            RCC_GEN_LOCK: begin
                if (osc_rise) begin
                    edges_next = edges_reg + 1'b1;
                end
                if (edges_reg == RCC_LCNT_W'(LOCK_EDGES)) begin
                    state_next = RCC_GEN_RUN;
                end
            end
            RCC_GEN_RUN: begin
                div_next = div_reg + 1'b1;
            end
            default: state_next = RCC_GEN_OFF;
        endcase
        if (!cif.gen_enable) begin
            state_next = RCC_GEN_OFF;
            div_next = '0;
        end
    end

    always_ff @(posedge ref_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            state_reg <= RCC_GEN_OFF;
            edges_reg <= '0;
            osc_prev_reg <= 1'b0;
            div_reg <= '0;
        end else begin
            state_reg <= state_next;
            edges_reg <= edges_next;
            osc_prev_reg <= osc_prev_next;
            div_reg <= div_next;
        end
    end

    assign cif.running = (state_reg == RCC_GEN_RUN);
    assign cif.memory_clock = div_reg[0];
    assign cif.system_clock = cif.half_speed ? div_reg[1] : div_reg[0];
    // external source drives constant high, crystal gets inverted feedback
    assign cif.osc_out = (cif.mode == RCC_XTAL_X16) ? ~cif.osc_sync : 1'b1;
    assign cif.mult = rcc_mult(cif.mode);
endmodule

// >>> verilog/rcc_reset_config.sv
// reset pin handling, strap capture and start of the clock generator
// assumes board logic drives reset pin, clock enable, straps and oscillator
`timescale 1ns/1ps
module rcc_reset_config
    import rcc_pkg::*;
#(
    parameter int RESET_CYC = RCC_RESET_CYC,
    parameter int LOCK_EDGES = RCC_LOCK_EDGES
) (
    input wire logic ref_clk_in,                      // core clock, 40 MHz
    input wire logic rstn_in,                         // power-on reset, active low
    input wire logic reset_pin_n_in,                  // device reset pin, active low
    input wire logic clock_gen_enable_in,             // clock generator enable pin
    input wire logic osc_in,                          // oscillator or crystal input
    input wire logic [RCC_DATA_W-1:0] data_strap_in,  // data pins 6:0
    input wire logic [RCC_ADDR_W-1:0] addr_strap_in,  // address pins 19:2
    output logic [RCC_DATA_W-1:0] config_data_out,   // captured data straps
    output logic [RCC_ADDR_W-1:0] config_addr_out,   // captured address straps
    output logic config_valid_out,                    // straps captured, set on reset pin release even if the reset was short
    output logic reset_short_out,                     // last reset was too short
    output logic core_reset_n_out,                    // internal reset, active low
    output logic clock_running_out,                   // generator running
    output logic [4:0] clock_mult_out,                // selected multiplication factor
    output logic memory_clock_out,                    // memory clock
    output logic system_clock_out,                    // system clock
    output logic osc_out                              // oscillator output pin
);
    rcc_clk_if cif ();

    typedef enum logic [1:0] {
        RCC_RST_HOLD = 2'b00,
        RCC_RST_RUN = 2'b01
    } rcc_rst_state_t;

    logic [RCC_SYNC_W-1:0] rst_sync_reg, en_sync_reg, osc_sync_reg;
    logic [RCC_DATA_W-1:0] data_s1_reg, data_s2_reg;
    logic [RCC_ADDR_W-1:0] addr_s1_reg, addr_s2_reg;
    rcc_rst_state_t state_reg, state_next;
    logic [RCC_DATA_W-1:0] data_reg, data_next;
    logic [RCC_ADDR_W-1:0] addr_reg, addr_next;
    logic [RCC_RCNT_W-1:0] rcnt_reg, rcnt_next;
    logic valid_reg, valid_next;
    logic short_reg, short_next;
    logic pin_low;
    logic long_enough;

    // two-stage synchronisers; only the second stage is read
    always_ff @(posedge ref_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            rst_sync_reg <= '0;
            en_sync_reg <= '0;
            osc_sync_reg <= '0;
            data_s1_reg <= RCC_DATA_RST;
            data_s2_reg <= RCC_DATA_RST;
            addr_s1_reg <= RCC_ADDR_RST;
            addr_s2_reg <= RCC_ADDR_RST;
        end else begin
            rst_sync_reg <= {rst_sync_reg[0], reset_pin_n_in};
            en_sync_reg <= {en_sync_reg[0], clock_gen_enable_in};
            osc_sync_reg <= {osc_sync_reg[0], osc_in};
            data_s1_reg <= data_strap_in;
            data_s2_reg <= data_s1_reg;
            addr_s1_reg <= addr_strap_in;
            addr_s2_reg <= addr_s1_reg;
        end
    end

    assign pin_low = ~rst_sync_reg[1];
    assign long_enough = (rcnt_reg >= RCC_RCNT_W'(RESET_CYC));

    always_comb begin
        state_next = state_reg;
        data_next = data_reg;
        addr_next = addr_reg;
        rcnt_next = rcnt_reg;
        valid_next = valid_reg;
        short_next = short_reg;
        unique case (state_reg)
            RCC_RST_HOLD: begin
                // data straps follow the pins while reset is low
                data_next = data_s2_reg;
                // address straps follow the pins while reset is low
                addr_next = addr_s2_reg;
                // measure the low time in core clocks
                if (!long_enough) begin
                    rcnt_next = rcnt_reg + 1'b1;
                end
                if (!pin_low) begin
                    state_next = RCC_RST_RUN;
                    valid_next = 1'b1;
                    short_next = ~long_enough;
                end
            end
            // straps frozen until reset falls again
            RCC_RST_RUN: begin
                if (pin_low) begin
                    state_next = RCC_RST_HOLD;
                    valid_next = 1'b0;
                    // the edge that saw the pin low is the first low cycle
                    rcnt_next = RCC_RCNT_W'(1);
                end
            end
            default: state_next = RCC_RST_HOLD;
        endcase
    end

    always_ff @(posedge ref_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            state_reg <= RCC_RST_HOLD;
            data_reg <= RCC_DATA_RST;
            addr_reg <= RCC_ADDR_RST;
            rcnt_reg <= '0;
            valid_reg <= 1'b0;
            short_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            data_reg <= data_next;
            addr_reg <= addr_next;
            rcnt_reg <= rcnt_next;
            valid_reg <= valid_next;
            short_reg <= short_next;
        end
    end

    // generator enable taken from the synchronised pin
    assign cif.gen_enable = en_sync_reg[1];
    // oscillator ratio chosen by the captured straps
    assign cif.mode = rcc_osc_mode_t'(data_reg[RCC_MODE_LSB +: RCC_MODE_W]);
    // speed choice from the captured straps
    assign cif.half_speed = data_reg[RCC_HALF_BIT];
    assign cif.osc_sync = osc_sync_reg[1];

    rcc_clock_gen #(
        .LOCK_EDGES(LOCK_EDGES)
    ) u_gen (
        .ref_clk_in(ref_clk_in),
        .rstn_in(rstn_in),
        .cif(cif)
    );

    assign config_data_out = data_reg;
    assign config_addr_out = addr_reg;
    assign config_valid_out = valid_reg;
    assign reset_short_out = short_reg;
    assign core_reset_n_out = valid_reg & ~short_reg & cif.running;
    assign clock_running_out = cif.running;
    assign clock_mult_out = cif.mult;
    assign memory_clock_out = cif.memory_clock;
    assign system_clock_out = cif.system_clock;
    assign osc_out = cif.osc_out;
endmodule

// >>> dv/rcc_props.sv
// checker for strap capture and clock start
// sees only the ports of rcc_reset_config, bound from the testbench
`timescale 1ns/1ps
module rcc_props
    import rcc_pkg::*;
(
    input wire logic ref_clk_in, // core clock
    input wire logic rstn_in, // async reset
    input wire logic reset_pin_n_in, // reset pin
    input wire logic clock_gen_enable_in, // enable pin
    input wire logic [RCC_DATA_W-1:0] config_data_out, // data straps
    input wire logic [RCC_ADDR_W-1:0] config_addr_out, // addr straps
    input wire logic config_valid_out, // captured
    input wire logic reset_short_out, // short reset
    input wire logic core_reset_n_out, // internal reset
    input wire logic clock_running_out, // running
    input wire logic [4:0] clock_mult_out, // factor
    input wire logic memory_clock_out, // memory clock
    input wire logic system_clock_out, // system clock
    input wire logic osc_out // oscillator out
);
    default clocking cb @(posedge ref_clk_in); endclocking
    default disable iff (!rstn_in);
    a_straps_frozen: assert property (
        config_valid_out && $past(config_valid_out) && $past(reset_pin_n_in, 3)
        |-> $stable(config_data_out) && $stable(config_addr_out)) else $error("straps moved");
    a_valid_drop: assert property (
        $fell(reset_pin_n_in) |-> ##[1:4] !config_valid_out) else $error("valid stayed");
    a_valid_rise: assert property (
        $rose(reset_pin_n_in) ##1 reset_pin_n_in [*4] |-> config_valid_out)
        else $error("no capture");
    a_mult_map: assert property (
        clock_mult_out == (5'h01 << (config_data_out[2:1] == 2'h3 ? 3'h4
        : {1'b0, config_data_out[2:1]}))) else $error("bad factor");
    a_osc_high: assert property (
        clock_mult_out != 5'h10 && $past(clock_mult_out) != 5'h10 |-> osc_out)
        else $error("osc out low");
    a_gen_off: assert property (
        !clock_gen_enable_in [*4] |-> !clock_running_out) else $error("runs disabled");
    a_idle_clocks: assert property (
        !clock_running_out [*3] |-> !memory_clock_out && !system_clock_out)
        else $error("clock while idle");
    a_mem_half: assert property (
        clock_running_out [*3] |-> memory_clock_out != $past(memory_clock_out))
        else $error("memory clock stuck");
    a_sys_full: assert property (
        clock_running_out [*3] && !config_data_out[RCC_HALF_BIT]
        |-> system_clock_out == memory_clock_out) else $error("full speed wrong");
    a_sys_half: assert property (
        clock_running_out [*5] && config_data_out[RCC_HALF_BIT]
        |-> system_clock_out != $past(system_clock_out, 2)) else $error("half speed wrong");
    a_core_reset: assert property (
        core_reset_n_out |-> config_valid_out && !reset_short_out && clock_running_out)
        else $error("core out of reset early");
    cover property (reset_short_out);
    cover property ($rose(clock_running_out) && config_data_out[RCC_HALF_BIT]);
    cover property ($rose(config_valid_out));
endmodule

// >>> dv/rcc_board_model.sv
// board side: reset pin, straps, clock enable and oscillator
// driven through its tasks by the testbench
`timescale 1ns/1ps
module rcc_board_model
    import rcc_pkg::*;
(
    input wire logic ref_clk_in, // core clock
    output logic reset_pin_n_out = 1'b0, // reset pin
    output logic clock_gen_enable_out = 1'b0, // enable pin
    output logic osc_clk_out = 1'b0, // oscillator
    output logic [RCC_DATA_W-1:0] data_strap_out = RCC_DATA_RST, // data pins
    output logic [RCC_ADDR_W-1:0] addr_strap_out = RCC_ADDR_RST // address pins
);
    int osc_half = 1;
    int osc_cnt = 0;
    // oscillator runs free, so it is stable before any enable
    always @(posedge ref_clk_in) begin
        osc_cnt <= (osc_cnt + 1 >= osc_half) ? 0 : osc_cnt + 1;
        if (osc_cnt + 1 >= osc_half) osc_clk_out <= ~osc_clk_out;
    end
    // pin held low a count of core clocks
    task automatic pulse_reset(input logic [RCC_DATA_W-1:0] d, input logic [RCC_ADDR_W-1:0] a,
                               input int low_cyc);
        @(posedge ref_clk_in);
        #2;
        reset_pin_n_out = 1'b0;
        data_strap_out = d;
        addr_strap_out = a;
        repeat (low_cyc) @(posedge ref_clk_in);
        #2;
        reset_pin_n_out = 1'b1;
        repeat (4) @(posedge ref_clk_in);
        // later bus traffic moves the pins away from the straps
        #2;
        data_strap_out = ~d;
        addr_strap_out = ~a;
    endtask
    // enable only after the oscillator has settled
    task automatic set_enable(input logic en, input int half);
        osc_half = half;
        repeat (8) @(posedge ref_clk_in);
        #2;
        clock_gen_enable_out = en;
    endtask
endmodule

// >>> dv/testbench.sv
// self-checking bench for rcc_reset_config with the board model on its pins
// reset and lock counts shortened through parameters
`timescale 1ns/1ps
module testbench;
    import rcc_pkg::*;
    localparam int RST_CYC = 8;
    typedef struct packed {logic [6:0] d; logic [17:0] a; logic [4:0] m; int st;} rcc_row_t;
    rcc_row_t rows[4] = '{'{7'h00, 18'h2aaaa, 5'h01, 8}, '{7'h03, 18'h15555, 5'h02, 4},
                          '{7'h04, 18'h00000, 5'h04, 8}, '{7'h47, 18'h0f0f0, 5'h10, 4}};
    logic ref_clk_in = 1'b0;
    logic rstn_in = 1'b0;
    logic pin_n, en, osc, valid, short, core_n, run, mclk, sclk, osc_o;
    logic [6:0] dat, cdat;
    logic [17:0] adr, cadr;
    logic [4:0] mult;
    int bad_count = 0;
    int n_tests = 0;
    always #12.5 ref_clk_in = ~ref_clk_in;
    rcc_board_model u_rcc_board_model (.ref_clk_in(ref_clk_in), .reset_pin_n_out(pin_n),
        .clock_gen_enable_out(en), .osc_clk_out(osc), .data_strap_out(dat),
        .addr_strap_out(adr));
    rcc_reset_config #(.RESET_CYC(RST_CYC), .LOCK_EDGES(2)) u_rcc_reset_config (
        .ref_clk_in(ref_clk_in), .rstn_in(rstn_in), .reset_pin_n_in(pin_n),
        .clock_gen_enable_in(en), .osc_in(osc), .data_strap_in(dat), .addr_strap_in(adr),
        .config_data_out(cdat), .config_addr_out(cadr), .config_valid_out(valid),
        .reset_short_out(short), .core_reset_n_out(core_n), .clock_running_out(run),
        .clock_mult_out(mult), .memory_clock_out(mclk), .system_clock_out(sclk),
        .osc_out(osc_o));
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            bad_count++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    task automatic start_clocks(input int half, output int st);
        logic s;
        u_rcc_board_model.set_enable(1'b1, half);
        for (int w = 0; w < 200 && run !== 1'b1; w++) begin
            @(posedge ref_clk_in);
            #1;
        end
        repeat (3) @(posedge ref_clk_in);
        #1;
        s = sclk;
        st = 0;
        repeat (8) begin
            @(posedge ref_clk_in);
            #1;
            st += (sclk !== s);
            s = sclk;
        end
    endtask
    initial begin
        repeat (20000) @(posedge ref_clk_in);
        bad_count++;
        report_and_stop;
    end
    initial begin
        int st;
        repeat (4) @(posedge ref_clk_in);
        #1;
        check("cfg_data", cdat, RCC_DATA_RST);
        check("cfg_addr", cadr, RCC_ADDR_RST);
        $display("power-on reset done");
        #1;
        rstn_in = 1'b1;
        foreach (rows[i]) begin
            u_rcc_board_model.pulse_reset(rows[i].d, rows[i].a, RST_CYC);
            repeat (2) @(posedge ref_clk_in);
            #1;
            check("cfg_data", cdat, rows[i].d);
            check("cfg_addr", cadr, rows[i].a);
            check("valid", valid, 1);
            check("short", short, 0);
            check("mult", mult, rows[i].m);
            if (rows[i].m != 5'h10) check("osc_out", osc_o, 1);
            start_clocks(rows[i].m, st);
            check("running", run, 1);
            check("core_n", core_n, 1);
            check("sys_tog", st, rows[i].st);
            u_rcc_board_model.set_enable(1'b0, rows[i].m);
            repeat (5) @(posedge ref_clk_in);
            #1;
            check("stopped", run, 0);
            $display("row %0d done", i);
        end
        u_rcc_board_model.pulse_reset(7'h02, 18'h12345, 3);
        repeat (2) @(posedge ref_clk_in);
        #1;
        check("short", short, 1);
        check("cfg_data", cdat, 7'h02);
        start_clocks(2, st);
        check("core_n", core_n, 0);
        $display("short reset done");
        @(posedge ref_clk_in);
        #2;
        rstn_in = 1'b0;
        #1;
        check("cfg_data", cdat, RCC_DATA_RST);
        check("valid", valid, 0);
        check("running", run, 0);
        @(posedge ref_clk_in);
        #2;
        rstn_in = 1'b1;
        // pin already high: straps taken from the pins as they stand
        repeat (4) @(posedge ref_clk_in);
        #1;
        check("valid", valid, 1);
        check("cfg_data", cdat, 7'h7d);
        check("running", run, 0);
        $display("second reset done");
        report_and_stop;
    end
endmodule
bind rcc_reset_config rcc_props u_rcc_props (.ref_clk_in(ref_clk_in), .rstn_in(rstn_in),
    .reset_pin_n_in(reset_pin_n_in), .clock_gen_enable_in(clock_gen_enable_in),
    .config_data_out(config_data_out), .config_addr_out(config_addr_out),
    .config_valid_out(config_valid_out), .reset_short_out(reset_short_out),
    .core_reset_n_out(core_reset_n_out), .clock_running_out(clock_running_out),
    .clock_mult_out(clock_mult_out), .memory_clock_out(memory_clock_out),
    .system_clock_out(system_clock_out), .osc_out(osc_out));
